//--- hdl/io_seq_pkg.sv
// Purpose: Shared constants for the channel transfer sequencer.
// Assumes: 18-bit data words, 16-bit memory addresses, 16 channels.
// Notes: Interrupt bases are kept as octal figures converted to hex.
package io_seq_pkg;
   localparam int WORD_W = 18;
   localparam int ADDR_W = 16;
   localparam int CM_AW = 8;
   localparam int NUM_CH = 16;
   localparam int CH_W = 4;
   localparam int GROUP_SIZE = 4;
   localparam int NUM_GROUP = NUM_CH / GROUP_SIZE;
   localparam int GRP_W = 2;
   localparam int BUF_DEPTH = 2;
   // Control words: two per direction, four per channel
   localparam logic [CM_AW-1:0] CM_BASE = 8'h00;
   localparam int CM_CH_SHIFT = 2;
   localparam logic [CM_AW-1:0] CM_OUT_OFS = 8'h02;
   localparam logic [CM_AW-1:0] CM_NEXT = 8'h01;
   // Interrupt store and entrance locations (101 and 100 octal)
   localparam logic [ADDR_W-1:0] INT_CODE_BASE = 16'h0041;
   localparam logic [ADDR_W-1:0] INT_ENTRY_BASE = 16'h0040;
   // Extra 200 octal for channels 10 octal and up
   localparam logic [ADDR_W-1:0] HIGH_CH_OFS = 16'h0080;
   localparam logic [CH_W-1:0] HIGH_CH_FIRST = 4'h8;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
   localparam logic [ADDR_W-1:0] ADDR_TWO = 16'h0002;
   localparam logic [1:0] HALF_LOW = 2'h1;
   localparam logic [1:0] HALF_BOTH = 2'h3;
   localparam logic [1:0] HALF_UP = 2'h2;
endpackage

//--- hdl/word_buffer.sv
// Purpose: Small valid/ready buffer between the sequencer and the channel pins.
// Assumes: Source and sink on the same clock.
// Notes: Full and empty are exact; a stalled sink backs up into the source.
`timescale 1ns/100ps
module word_buffer #(
   parameter int WIDTH = 23,
   parameter int DEPTH = 2
) (
   input wire logic clk_sys, // System clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic s_valid, // Word offered
   output logic s_ready, // Room for a word
   input wire logic [WIDTH-1:0] s_data, // Offered word
   output logic m_valid, // Word available
   input wire logic m_ready, // Sink takes the word
   output logic [WIDTH-1:0] m_data, // Oldest word
   output logic empty // Nothing held
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
   localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);
   logic [WIDTH-1:0] slot [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;
   logic push;
   logic pop;

   // Handshake terms
   assign s_ready = (count != FULL_COUNT);
   assign m_valid = (count != '0);
   assign empty = (count == '0);
   assign push = s_valid && s_ready;
   assign pop = m_valid && m_ready;
   assign m_data = slot[rd_ptr];

   // Storage, no reset needed on data
   always_ff @(posedge clk_sys) begin
      if (push) begin
         slot[wr_ptr] <= s_data;
      end
   end

   // Pointers wrap at the configured depth
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
         end
      end
   end

   // Occupancy
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         count <= '0;
      end else if (push && !pop) begin
         count <= count + 1'b1;
      end else if (pop && !push) begin
         count <= count - 1'b1;
      end
   end
endmodule

//--- hdl/io_buffer_transfer_sequencer.sv
// Purpose: Channel transfer sequencer: buffered words, overrides, interrupt entry.
// Assumes: Control and main memory answer reads one cycle after the strobe.
// Notes: One memory cycle per step; output words leave through a two-entry buffer.
// Operation
// - Override forces output word without a request.
// - Intercomputer override waits for resume; program stalls.
// - Request scan overlaps instructions and transfers.
// - Step one reads current-address word.
// - Step two reads terminal word, compares.
// - Step three writes back, alongside first transfer.
// - Step four moves word; dual mode pairs.
// - Step five only for output transfers.
// - Buffer ends after step three.
// - Single interrupt stores code at 101+2k.
// - Then fetch from entrance 100+2k.
// - Dual interrupt stores odd upper, even lower.
// - Dual interrupt fetches odd-channel entrance.
// - k is odd channel; add 200 high.
// - Receiver acknowledge sets group resume flip-flop.
`timescale 1ns/100ps
module io_buffer_transfer_sequencer #(
   parameter int NCH = io_seq_pkg::NUM_CH,
   parameter int W = io_seq_pkg::WORD_W
) (
   input wire logic clk_sys, // System clock, 125 MHz
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic [NCH-1:0] in_req, // Input request pins
   input wire logic [NCH-1:0] out_req, // Output request pins, resume on intercomputer
   input wire logic [NCH*W-1:0] in_data, // Input data pins, channel c at c*W
   input wire logic [NCH-1:0] intercomputer, // Intercomputer selection switches
   input wire logic [NCH/2-1:0] dual_mode, // Pair switch: dual-channel
   input wire logic [NCH/2-1:0] external_index_mode, // Pair switch: index mode
   input wire logic [NCH-1:0] ch_in_active, // Program: input buffer active
   input wire logic [NCH-1:0] ch_out_active, // Program: output buffer active
   input wire logic override_req, // Program override pulse
   input wire logic [io_seq_pkg::CH_W-1:0] override_ch, // Override channel
   input wire logic set_resume, // Program set-resume pulse
   input wire logic [io_seq_pkg::GRP_W-1:0] set_resume_group, // Group to set
   output logic prog_stall, // Program held while override pending
   output logic [NCH/io_seq_pkg::GROUP_SIZE-1:0] resume, // Resume flip-flops
   output logic [io_seq_pkg::CM_AW-1:0] cm_addr, // Control memory address
   output logic cm_rd, // Control memory read strobe
   output logic cm_wr, // Control memory write strobe
   output logic [io_seq_pkg::ADDR_W-1:0] cm_wdata, // Control word written
   input wire logic [io_seq_pkg::ADDR_W-1:0] cm_rdata, // Control word read
   output logic [io_seq_pkg::ADDR_W-1:0] mm_addr, // Main memory address
   output logic mm_rd, // Main memory read strobe
   output logic mm_wr, // Main memory write strobe
   output logic [1:0] mm_half, // Write halves: 1 low, 2 upper
   output logic [2*W-1:0] mm_wdata, // Write data, upper and lower
   input wire logic [W-1:0] mm_rdata, // Read data
   output logic [NCH-1:0] in_ack, // Input acknowledge pulses
   output logic [NCH-1:0] out_ack, // Output acknowledge pulses
   output logic [W-1:0] out_data, // Output word
   output logic [io_seq_pkg::CH_W-1:0] out_ch, // Channel of output word
   output logic out_both, // Drive word on both channels of pair
   output logic out_valid, // Output word present
   input wire logic out_ready, // Channel pins take the word
   output logic buf_term, // Buffer termination pulse
   output logic [io_seq_pkg::CH_W-1:0] buf_term_ch, // Terminating channel
   input wire logic int_req, // External interrupt pending
   input wire logic [io_seq_pkg::CH_W-1:0] int_ch, // Interrupting channel
   input wire logic int_dual, // Dual or index-mode interrupt
   input wire logic [W-1:0] int_code_odd, // Odd-channel code
   input wire logic [W-1:0] int_code_even, // Even-channel code
   output logic int_ack, // Interrupt entered, pulse
   output logic [io_seq_pkg::ADDR_W-1:0] fetch_addr, // Next instruction address
   output logic fetch_valid // Fetch request pulse
);
   localparam int CW = io_seq_pkg::CH_W;
   localparam int AW = io_seq_pkg::ADDR_W;
   localparam int PL_W = W + CW + 1;
   localparam int NGRP = NCH / io_seq_pkg::GROUP_SIZE;

   typedef enum logic [3:0] {
      ST_IDLE, ST_RD_CUR, ST_RD_TERM, ST_WB_XFER1, ST_XFER2, ST_CAPTURE,
      ST_INT_CODE1, ST_INT_CODE2, ST_INT_FETCH
   } seq_state_t;

   seq_state_t state;
   logic [NCH-1:0] in_req_m, in_req_s, out_req_m, out_req_s, out_req_d;
   logic [NCH-1:0] ic_m, ic_s;
   logic [NCH/2-1:0] dual_m, dual_s, xidx_m, xidx_s;
   logic [NCH*W-1:0] data_m, data_s;
   logic [NCH-1:0] in_served, out_served;
   logic [NCH-1:0] in_pend, out_pend;
   logic scan_valid, scan_dir;
   logic [CW-1:0] scan_ch;
   logic ovr_pend;
   logic [CW-1:0] ovr_ch;
   logic [CW-1:0] cur_ch;
   logic cur_dir, cur_dual, cur_xidx, cur_forced;
   logic [AW-1:0] cur_addr;
   logic last_word, term_hit;
   localparam int CM_AW_T = io_seq_pkg::CM_AW;
   localparam int GRP_T = io_seq_pkg::GRP_W;
   logic [CM_AW_T-1:0] cm_index;
   logic buf_s_valid, buf_s_ready, buf_empty;
   logic [PL_W-1:0] buf_s_data, buf_m_data;
   logic start_ok, ovr_go;
   logic [CW-1:0] pair_even, pair_odd, int_k;
   logic [AW-1:0] int_hi_ofs;

   // Two flip-flops on every request pin, data pin and switch before any logic reads them; out_ready and int_req go straight in
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         {in_req_m, in_req_s, out_req_m, out_req_s, out_req_d, ic_m, ic_s} <= '0;
         {dual_m, dual_s, xidx_m, xidx_s, data_m, data_s} <= '0;
      end else begin
         {in_req_m, out_req_m, ic_m, dual_m, xidx_m, data_m} <= {in_req, out_req,
            intercomputer, dual_mode, external_index_mode, in_data};
         {in_req_s, out_req_s, out_req_d, ic_s} <= {in_req_m, out_req_m, out_req_s, ic_m};
         {dual_s, xidx_s, data_s} <= {dual_m, xidx_m, data_m};
      end
   end

   // Served from the start of its transfer until the pin drops, so a scan
   // taken before the acknowledge cannot start the same request twice
   generate
      for (genvar c = 0; c < NCH; c++) begin : g_served
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               {in_served[c], out_served[c]} <= 2'h0;
            end else begin
               if (state == ST_RD_CUR && !cur_dir && cur_ch == CW'(c)) begin
                  in_served[c] <= 1'b1;
               end else if (!in_req_s[c]) begin
                  in_served[c] <= 1'b0;
               end
               if (state == ST_RD_CUR && cur_dir && cur_ch == CW'(c)) begin
                  out_served[c] <= 1'b1;
               end else if (!out_req_s[c]) begin
                  out_served[c] <= 1'b0;
               end
            end
         end
         // Intercomputer outputs are left out of the scan; they go only by override
         assign in_pend[c] = in_req_s[c] && ch_in_active[c] && !in_served[c];
         assign out_pend[c] = ch_out_active[c] && !ic_s[c] && out_req_s[c]
            && !out_served[c];
      end
   endgenerate
   // Scan runs every cycle, whether the sequencer is busy or not
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         {scan_valid, scan_dir, scan_ch} <= '0;
      end else begin
         {scan_valid, scan_dir, scan_ch} <= '0;
         for (int c = NCH - 1; c >= 0; c--) begin
            if (in_pend[c] || out_pend[c]) begin
               scan_valid <= 1'b1;
               scan_dir <= !in_pend[c];
               scan_ch <= CW'(c);
            end
         end
      end
   end
   // Override waits for idle and an empty buffer; intercomputer channels also need resume
   assign ovr_go = ovr_pend && (!ic_s[ovr_ch] || resume[ovr_ch[CW-1:2]]);
   assign prog_stall = ovr_pend;
   assign start_ok = buf_empty && buf_s_ready;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ovr_pend <= 1'b0;
         ovr_ch <= '0;
      end else if (override_req && !ovr_pend) begin
         ovr_pend <= 1'b1;
         ovr_ch <= override_ch;
      end else if (state == ST_IDLE && !int_req && ovr_go && start_ok) begin
         ovr_pend <= 1'b0;
      end
   end
   // Resume per group: set by receiver acknowledge or program, cleared when
   // an intercomputer word is launched; set wins over clear
   generate
      for (genvar g = 0; g < NGRP; g++) begin : g_resume
         logic ack_edge;
         logic launch;
         always_comb begin
            ack_edge = 1'b0;
            for (int j = 0; j < io_seq_pkg::GROUP_SIZE; j++) begin
               if (ic_s[g*4+j] && out_req_s[g*4+j] && !out_req_d[g*4+j]) begin
                  ack_edge = 1'b1;
               end
            end
         end
         assign launch = state == ST_IDLE && !int_req && ovr_go && start_ok
            && ovr_ch[CW-1:2] == GRP_T'(g) && ic_s[ovr_ch];
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               resume[g] <= 1'b1;
            end else if (ack_edge || (set_resume && set_resume_group == GRP_T'(g))) begin
               resume[g] <= 1'b1;
            end else if (launch) begin
               resume[g] <= 1'b0;
            end
         end
      end
   endgenerate
   // Control word location: address generator, or index from the odd channel
   assign pair_even = {cur_ch[CW-1:1], 1'b0};
   assign pair_odd = {cur_ch[CW-1:1], 1'b1};
   always_comb begin
      if (cur_xidx) begin
         cm_index = data_s[pair_odd*W +: CM_AW_T];
      end else begin
         cm_index = io_seq_pkg::CM_BASE + CM_AW_T'({cur_ch, 2'b00})
            + (cur_dir ? io_seq_pkg::CM_OUT_OFS : '0);
      end
   end
   // Terminal compare; dual takes two words
   assign last_word = (cur_addr == cm_rdata);
   assign term_hit = last_word || (cur_dual && (cur_addr + io_seq_pkg::ADDR_ONE == cm_rdata));
   // Interrupt addresses use the odd channel number
   assign int_k = {int_ch[CW-1:1], 1'b1};
   assign int_hi_ofs = (int_k >= io_seq_pkg::HIGH_CH_FIRST) ? io_seq_pkg::HIGH_CH_OFS : '0;
   // Step sequencer
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         {cur_ch, cur_dir, cur_dual, cur_xidx, cur_forced, cur_addr} <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (int_req) begin
                  state <= int_ack ? ST_IDLE : ST_INT_CODE1; // Request lags its ack
               end else if (ovr_go && start_ok) begin
                  state <= ST_RD_CUR;
                  cur_ch <= ovr_ch;
                  cur_dir <= 1'b1;
                  cur_dual <= dual_s[ovr_ch[CW-1:1]];
                  cur_xidx <= 1'b0;
                  cur_forced <= 1'b1;
               end else if (scan_valid && (!scan_dir || start_ok)) begin
                  state <= ST_RD_CUR;
                  cur_ch <= scan_ch;
                  cur_dir <= scan_dir;
                  cur_dual <= dual_s[scan_ch[CW-1:1]] && !xidx_s[scan_ch[CW-1:1]];
                  cur_xidx <= xidx_s[scan_ch[CW-1:1]] && scan_ch[0];
                  cur_forced <= 1'b0;
               end
            end
            ST_RD_CUR: state <= ST_RD_TERM;
            ST_RD_TERM: begin
               cur_addr <= cm_rdata;
               state <= ST_WB_XFER1;
            end
            ST_WB_XFER1: begin
               if (cur_dual && !last_word) begin
                  state <= ST_XFER2;
               end else if (cur_dir) begin
                  state <= ST_CAPTURE;
               end else begin
                  state <= ST_IDLE;
               end
            end
            ST_XFER2: state <= cur_dir ? ST_CAPTURE : ST_IDLE;
            ST_CAPTURE: state <= ST_IDLE;
            ST_INT_CODE1: state <= int_dual ? ST_INT_CODE2 : ST_INT_FETCH;
            ST_INT_CODE2: state <= ST_INT_FETCH;
            ST_INT_FETCH: state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Control memory: read current, read terminal, write back
   always_comb begin
      cm_rd = 1'b0;
      cm_wr = 1'b0;
      cm_addr = cm_index;
      cm_wdata = '0;
      case (state)
         ST_RD_CUR: cm_rd = 1'b1;
         ST_RD_TERM: begin
            cm_rd = 1'b1;
            cm_addr = cm_index + io_seq_pkg::CM_NEXT;
         end
         ST_WB_XFER1: begin
            cm_wr = 1'b1;
            cm_wdata = cur_addr + ((cur_dual && !last_word) ? io_seq_pkg::ADDR_TWO
               : io_seq_pkg::ADDR_ONE);
         end
         default: ;
      endcase
   end

   // Main memory: data words and interrupt code stores
   always_comb begin
      mm_addr = cur_addr;
      mm_rd = 1'b0;
      mm_wr = 1'b0;
      mm_half = io_seq_pkg::HALF_LOW;
      mm_wdata = '0;
      case (state)
         ST_WB_XFER1: begin
            mm_rd = cur_dir;
            mm_wr = !cur_dir;
            mm_wdata = {{W{1'b0}}, data_s[(cur_xidx ? pair_even :
               (cur_dual ? pair_even : cur_ch))*W +: W]};
         end
         ST_XFER2: begin
            mm_addr = cur_addr + io_seq_pkg::ADDR_ONE;
            mm_rd = cur_dir;
            mm_wr = !cur_dir;
            mm_wdata = {{W{1'b0}}, data_s[pair_odd*W +: W]};
         end
         ST_INT_CODE1: begin
            mm_addr = io_seq_pkg::INT_CODE_BASE + AW'({int_k, 1'b0}) + int_hi_ofs;
            mm_wr = 1'b1;
            mm_half = int_dual ? io_seq_pkg::HALF_UP : io_seq_pkg::HALF_LOW;
            mm_wdata = int_dual ? {int_code_odd, {W{1'b0}}} : {{W{1'b0}}, int_code_odd};
         end
         ST_INT_CODE2: begin
            mm_addr = io_seq_pkg::INT_CODE_BASE + AW'({int_k, 1'b0}) + int_hi_ofs;
            mm_wr = 1'b1;
            mm_wdata = {{W{1'b0}}, int_code_even};
         end
         default: ;
      endcase
   end

   // Output words read last step go into the buffer; room was checked at start
   assign buf_s_valid = cur_dir && (state == ST_XFER2 || state == ST_CAPTURE);
   assign buf_s_data = {mm_rdata, cur_ch, cur_xidx};

   word_buffer #(
      .WIDTH(PL_W),
      .DEPTH(io_seq_pkg::BUF_DEPTH)
   ) u_out_buf (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .s_valid(buf_s_valid),
      .s_ready(buf_s_ready),
      .s_data(buf_s_data),
      .m_valid(out_valid),
      .m_ready(out_ready),
      .m_data(buf_m_data),
      .empty(buf_empty)
   );
   assign out_data = buf_m_data[PL_W-1 -: W];
   assign out_ch = buf_m_data[CW:1];
   assign out_both = buf_m_data[0];

   // Acknowledges, termination and interrupt entry
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         {in_ack, out_ack, buf_term, buf_term_ch, int_ack, fetch_valid, fetch_addr} <= '0;
      end else begin
         {in_ack, out_ack, buf_term, int_ack, fetch_valid} <= '0;
         if (out_valid && out_ready) begin
            out_ack[buf_m_data[CW:1]] <= 1'b1;
         end
         if (!cur_dir && ((state == ST_WB_XFER1 && !(cur_dual && !last_word))
               || state == ST_XFER2)) begin
            in_ack[cur_ch] <= 1'b1;
         end
         if (state == ST_WB_XFER1 && term_hit && !cur_forced) begin
            buf_term <= 1'b1;
            buf_term_ch <= cur_ch;
         end
         if (state == ST_INT_FETCH) begin
            int_ack <= 1'b1;
            fetch_valid <= 1'b1;
            fetch_addr <= io_seq_pkg::INT_ENTRY_BASE + AW'({int_k, 1'b0}) + int_hi_ofs;
         end
      end
   end
endmodule

//--- dv/io_buffer_transfer_sequencer_asserts.sv
// Purpose: Port checks for the channel transfer sequencer.
// Assumes: One clock, synchronous active-low reset.
// Notes: Write-back check allows a skipped write.
`timescale 1ns/100ps
module io_buffer_transfer_sequencer_checker #(
   parameter int NCH = 16,
   parameter int W = 18
) (
   input logic clk_sys, // System clock
   input logic rst_n, // Reset, active low
   input logic override_req, // Override pulse
   input logic prog_stall, // Program hold
   input logic [7:0] cm_addr, // Control address
   input logic cm_rd, // Control read
   input logic cm_wr, // Control write
   input logic [15:0] mm_addr, // Main address
   input logic mm_rd, // Main read
   input logic mm_wr, // Main write
   input logic [1:0] mm_half, // Write halves
   input logic [NCH-1:0] in_ack, // Input acks
   input logic [NCH-1:0] out_ack, // Output acks
   input logic out_valid, // Word present
   input logic out_ready, // Pins take word
   input logic [W-1:0] out_data, // Output word
   input logic [3:0] out_ch, // Output channel
   input logic buf_term, // Termination
   input logic [15:0] fetch_addr, // Fetch address
   input logic fetch_valid // Fetch pulse
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Transfer steps, memory side
   stall_on_override_a: assert property (override_req && !prog_stall |=> prog_stall)
      else $error("program not held after override");
   terminal_read_next_a: assert property (cm_rd && !cm_addr[0] |=> cm_rd && cm_addr == $past(cm_addr) + 8'h01)
      else $error("terminal word not read from next location");
   write_back_slot_a: assert property (cm_rd && cm_addr[0] |=> !cm_rd && (!cm_wr || cm_addr == $past(cm_addr) - 8'h01))
      else $error("write-back to wrong location");
   write_with_word_a: assert property (cm_wr |-> mm_wr || mm_rd)
      else $error("write-back not alongside word transfer");
   code_halves_a: assert property (mm_wr && mm_half == 2'h2 |-> mm_addr[0] ##1 mm_wr && mm_half == 2'h1 && mm_addr == $past(mm_addr))
      else $error("interrupt code halves out of order");
   entrance_shape_a: assert property (fetch_valid |-> fetch_addr[15:8] == 8'h00 && fetch_addr[6:5] == 2'h2 && !fetch_addr[0] && fetch_addr[4] == fetch_addr[7])
      else $error("bad interrupt entrance address");
   // Channel side
   in_ack_pulse_a: assert property (in_ack != '0 |=> in_ack == '0)
      else $error("input acknowledge longer than one cycle");
   out_ack_cause_a: assert property (out_ack != '0 |-> $past(out_valid) && $past(out_ready))
      else $error("output acknowledge without handover");
   stalled_word_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_ch))
      else $error("stalled output word changed");
   term_pulse_a: assert property (buf_term |=> !buf_term)
      else $error("termination longer than one cycle");
endmodule
bind io_buffer_transfer_sequencer io_buffer_transfer_sequencer_checker #(.NCH(NCH), .W(W)) u_chk (.*);

//--- dv/io_peripheral_model.sv
// Purpose: Peripheral that takes output words from the channel pins.
// Assumes: Same clock as the sequencer.
// Notes: Takes any word, asked for or forced; stall holds it off.
`timescale 1ns/100ps
module io_peripheral_model (
   input logic clk_sys, // System clock
   input logic rst_n, // Reset, active low
   input logic out_valid, // Word present
   input logic [17:0] out_data, // Word
   input logic stall, // Bench holds the sink off
   output logic out_ready, // Sink takes word
   output logic [17:0] got_word, // Last word taken
   output int got_count // Words taken
);
   // Forced words taken like any; a lost word is fine
   assign out_ready = !stall;
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         got_count <= 0;
      end else if (out_valid && out_ready) begin
         got_word <= out_data;
         got_count <= got_count + 1;
      end
   end
endmodule

//--- dv/io_buffer_transfer_sequencer_bench.sv
// Purpose: Self-checking bench for the channel transfer sequencer.
// Assumes: Memories answer one cycle after the strobe.
// Notes: Index and dual switches stay off.
`timescale 1ns/100ps
module io_buffer_transfer_sequencer_bench;
   logic clk_sys = 1'b0, rst_n = 1'b0, stall = 1'b0, int_dual = 1'b0;
   logic override_req = 1'b0, set_resume = 1'b0, int_req = 1'b0;
   logic [15:0] in_req = 16'h0000, out_req = 16'h0000, intercomputer = 16'h0200;
   logic [15:0] ch_in_active = 16'h0000, ch_out_active = 16'h0000, in_ack, out_ack;
   logic [7:0] dual_mode = 8'h00, external_index_mode = 8'h00, cm_addr;
   logic [287:0] in_data = 288'h0;
   logic [3:0] override_ch = 4'h9, int_ch = 4'h0, out_ch, buf_term_ch, term_ch, resume;
   logic [1:0] set_resume_group = 2'h2, mm_half;
   logic [17:0] int_code_odd = 18'h0ABCD, int_code_even = 18'h01234;
   logic [17:0] mm_rdata, out_data, got_word;
   logic [15:0] cm_rdata, cm_wdata, mm_addr, fetch_addr, fetch_q, ack_seen;
   logic [35:0] mm_wdata;
   logic cm_rd, cm_wr, mm_rd, mm_wr, out_both, out_valid, out_ready, buf_term;
   logic prog_stall, int_ack, fetch_valid, term_seen, fetch_seen, int_seen;
   logic [15:0] cm [0:255];
   logic [17:0] mm_lo [0:1023];
   logic [17:0] mm_hi [0:1023];
   int errors = 0, checked = 0, got_count, n, b;
   io_buffer_transfer_sequencer DUT (.*);
   io_peripheral_model u_peer (.*);
   always #4 clk_sys = ~clk_sys;
   // Memories and sticky event flags; flags are cleared by the scenarios
   always @(posedge clk_sys) begin
      if (cm_rd) cm_rdata <= cm[cm_addr];
      if (cm_wr) cm[cm_addr] <= cm_wdata;
      if (mm_rd) mm_rdata <= mm_lo[mm_addr[9:0]];
      if (mm_wr && mm_half[0]) mm_lo[mm_addr[9:0]] <= mm_wdata[17:0];
      if (mm_wr && mm_half[1]) mm_hi[mm_addr[9:0]] <= mm_wdata[35:18];
      ack_seen <= ack_seen | in_ack | out_ack;
      if (buf_term) term_seen <= 1'b1;
      if (buf_term) term_ch <= buf_term_ch;
      if (int_ack) int_seen <= 1'b1;
      if (fetch_valid) fetch_seen <= 1'b1;
      if (fetch_valid) fetch_q <= fetch_addr;
   end
   task tick();
      @(posedge clk_sys);
      #1;
   endtask
   task chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task tally_and_finish();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Bounded wait for a channel acknowledge
   task wait_ack(input int c);
      for (n = 0; n < 60 && ack_seen[c] !== 1'b1; n++) tick();
      chk(ack_seen[c] === 1'b1, "no acknowledge");
   endtask
   task t_input();
      {cm[8], cm[9]} = {16'h0100, 16'h0100};
      in_data[36 +: 18] = 18'h2A5A5;
      {ch_in_active[2], ack_seen, term_seen} = {1'b1, 16'h0000, 1'b0};
      in_req[2] = 1'b1;
      wait_ack(2);
      {in_req[2], ch_in_active[2]} = 2'h0;
      chk(mm_lo[256] === 18'h2A5A5, "input word not stored");
      chk(cm[8] === 16'h0101, "current address not advanced");
      chk(term_seen === 1'b1 && term_ch === 4'h2, "no termination");
   endtask
   // Receiver stalls; the buffered word must wait intact
   task t_output();
      {cm[22], cm[23], mm_lo[512]} = {16'h0200, 16'h0205, 18'h1C3E7};
      {ch_out_active[5], stall, ack_seen, term_seen} = {2'h3, 16'h0000, 1'b0};
      out_req[5] = 1'b1;
      for (n = 0; n < 60 && out_valid !== 1'b1; n++) tick();
      repeat (6) tick();
      chk(out_valid === 1'b1 && out_data === 18'h1C3E7 && out_ch === 4'h5, "word lost");
      stall = 1'b0;
      wait_ack(5);
      {out_req[5], ch_out_active[5]} = 2'h0;
      chk(got_word === 18'h1C3E7 && cm[22] === 16'h0201, "output or write-back wrong");
      chk(term_seen === 1'b0, "early termination");
   endtask
   // Three forced words on an intercomputer channel, released two ways
   task t_override();
      {cm[38], cm[39], ch_out_active[9], b} = {16'h0300, 16'h0310, 1'b1, got_count};
      for (int k = 0; k < 3; k++) begin
         mm_lo[768 + k] = 18'h30000 | 18'(k);
         override_req = 1'b1;
         tick();
         override_req = 1'b0;
         tick();
         if (k > 0) begin
            repeat (8) tick();
            chk(prog_stall === 1'b1 && got_count == b + k, "ran without resume");
            if (k == 1) out_req[9] = 1'b1;
            else set_resume = 1'b1;
            tick();
            set_resume = 1'b0;
         end
         for (n = 0; n < 60 && got_count != b + k + 1; n++) tick();
         chk(got_word === (18'h30000 | 18'(k)) && prog_stall === 1'b0, "forced word");
         out_req[9] = 1'b0;
      end
      chk(resume === 4'hB, "resume not cleared by override");
   endtask
   // Single entry on channel 3, then dual entry on channel 13 octal
   task t_interrupt();
      logic [15:0] a;
      for (int k = 0; k < 2; k++) begin
         {int_ch, int_dual, a} = k ? {4'hB, 1'b1, 16'h00D7} : {4'h3, 1'b0, 16'h0047};
         {fetch_seen, int_seen, int_req} = 3'h1;
         for (n = 0; n < 60 && !(fetch_seen === 1'b1 && int_seen === 1'b1); n++) tick();
         int_req = 1'b0;
         chk(fetch_q === a - 16'h0001, "entrance address");
         chk(mm_lo[a[9:0]] === (k ? 18'h01234 : 18'h0ABCD), "low half code");
         if (k) chk(mm_hi[a[9:0]] === 18'h0ABCD, "upper half code");
      end
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      repeat (3) tick();
      chk(resume === 4'hF && out_valid === 1'b0 && prog_stall === 1'b0, "reset state");
      t_input();
      t_output();
      t_override();
      t_interrupt();
      tally_and_finish();
   end
endmodule
